/* design/setup_one_defs.vh */
// Purpose: constants for the setup register and clock multiplier control
// Assumes: 250 MHz core clock
// Notes: register indexes are chosen values
`ifndef SETUP_ONE_DEFS_VH
`define SETUP_ONE_DEFS_VH
`define SETUP_ONE_ADDR 3'h7
`define CMD_ADDR 3'h1
`define CMD_RESTART 8'h18
`define BIT_FAST_READ 7
`define BIT_UNDEF 6
`define BIT_MULT_HI 5
`define BIT_MULT_LO 4
`define BIT_ENH 3
`define BIT_SKIP_SYNC 2
`define SETUP_ONE_RESET 8'h00
`define MULT_20MHZ 2'h0
`define MULT_40MHZ 2'h1
`define CLK_MHZ 250
`define PLL_LOCK_US 8000
`define PLL_LOCK_CYCLES (`PLL_LOCK_US * `CLK_MHZ)
`endif

/* design/pll_wake_timer.v */
// Purpose: counts the multiplier lock time after a wake request
// Assumes: start is a one-cycle pulse
// Notes: locked stays high until reset
module pll_wake_timer #(
  parameter integer LOCK_CYCLES = 2000000
) (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire start,
  output reg locked
);
  reg [31:0] count;
  reg running;
  always @(posedge clk) begin
    if (reset) begin
      count <= 32'h0;
      running <= 1'b0;
      locked <= 1'b0;
    end else if (ce) begin
      if (start && !running && !locked) begin
        running <= 1'b1;
        count <= 32'h0;
      end else if (running) begin
        if (count == LOCK_CYCLES - 1) begin
          running <= 1'b0;
          locked <= 1'b1;
        end else begin
          count <= count + 32'h1;
        end
      end
    end
  end
endmodule

/* design/setup_clock_multiplier_config.v */
// Purpose: setup register with fast read, clock multiplier, enhanced and sync bits
// Assumes: host bus strobes are synchronous to clk and one cycle long
// Notes: core restart needs command restart code after the first multiplier change since reset
`include "setup_one_defs.vh"
module setup_clock_multiplier_config #(
  parameter integer LOCK_CYCLES = `PLL_LOCK_CYCLES
) (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire mux_bus,
  output reg [7:0] rdata,
  output reg fast_read_timing_sel,
  output reg fast_read_active,
  output reg clock_mult_sel_hi,
  output reg clock_mult_sel_lo,
  output reg enhanced_func_en,
  output reg skip_idle_sync,
  output reg mult_power_up,
  output reg mult_clk_40,
  output reg core_halted,
  output reg pll_locked
);
  localparam [2:0] ST_OFF = 3'b001;
  localparam [2:0] ST_WAKE = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;
  // bits that carry a defined function in this block
  localparam [7:0] FIELD_MASK = (8'h01 << `BIT_FAST_READ) | (8'h01 << `BIT_MULT_HI) |
    (8'h01 << `BIT_MULT_LO) | (8'h01 << `BIT_ENH) | (8'h01 << `BIT_SKIP_SYNC);
  reg [7:0] setup_one_control;
  reg [7:0] next_setup;
  reg [2:0] state;
  reg [2:0] next_state;
  reg mult_changed;
  reg next_mult_changed;
  reg wake_pulse;
  reg next_wake_pulse;
  reg next_core_halted;
  reg [7:0] next_rdata;
  reg next_fast_read_timing_sel;
  reg next_fast_read_active;
  reg next_clock_mult_sel_hi;
  reg next_clock_mult_sel_lo;
  reg next_enhanced_func_en;
  reg next_skip_idle_sync;
  reg next_mult_power_up;
  reg next_mult_clk_40;
  reg next_pll_locked;
  wire lock_done;
  wire [7:0] field_now;
  wire setup_wr = ce && wr && (addr == `SETUP_ONE_ADDR);
  wire setup_rd = ce && rd && (addr == `SETUP_ONE_ADDR);
  wire cmd_wr = ce && wr && (addr == `CMD_ADDR);
  wire restart_cmd = cmd_wr && (wdata == `CMD_RESTART);
  wire [1:0] new_mult = {wdata[`BIT_MULT_HI], wdata[`BIT_MULT_LO]};
  wire [1:0] cur_mult = {setup_one_control[`BIT_MULT_HI], setup_one_control[`BIT_MULT_LO]};
  // only the first multiplier change after reset counts; further ones are still stored but do not re-halt
  wire mult_change = setup_wr && (new_mult != cur_mult) && !mult_changed;
  // reserved codes wake the multiplier too, but never select 40 MHz
  wire wake_request = mult_change && (new_mult != `MULT_20MHZ);

  // bit 6 and the low bits are stored but drive no field output
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_field
      assign field_now[b] = FIELD_MASK[b] & setup_one_control[b];
    end
  endgenerate

  pll_wake_timer #(.LOCK_CYCLES(LOCK_CYCLES)) u_timer (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .start(wake_pulse),
    .locked(lock_done)
  );

  // next value of the stored register, halt flag and wake sequence
  always @* begin
    next_setup = setup_one_control;
    next_mult_changed = mult_changed;
    // the start pulse lasts one cycle so the timer arms once
    next_wake_pulse = 1'b0;
    next_core_halted = core_halted;
    next_state = state;
    if (setup_wr) begin
      next_setup = wdata;
    end
    if (mult_change) begin
      next_mult_changed = 1'b1;
    end
    if (mult_change) begin
      next_core_halted = 1'b1;
    end else if (restart_cmd) begin
      // restart on command code
      // restart does not wait for lock; the host keeps the settle time
      next_core_halted = 1'b0;
    end
    case (state)
      ST_OFF: begin
        if (wake_request) begin
          next_state = ST_WAKE;
          next_wake_pulse = 1'b1;
        end
      end
      ST_WAKE: begin
        // the timer owns the lock count; wait for its flag
        if (lock_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      setup_one_control <= `SETUP_ONE_RESET;
      mult_changed <= 1'b0;
      wake_pulse <= 1'b0;
      core_halted <= 1'b0;
      state <= ST_OFF;
    end else if (ce) begin
      setup_one_control <= next_setup;
      mult_changed <= next_mult_changed;
      wake_pulse <= next_wake_pulse;
      core_halted <= next_core_halted;
      state <= next_state;
    end
  end

  // next values of the registered outputs
  always @* begin
    next_rdata = rdata;
    if (setup_rd) begin
      next_rdata = setup_one_control;
    end
    next_fast_read_timing_sel = field_now[`BIT_FAST_READ];
    next_fast_read_active = field_now[`BIT_FAST_READ] && !mux_bus;
    next_clock_mult_sel_hi = field_now[`BIT_MULT_HI];
    next_clock_mult_sel_lo = field_now[`BIT_MULT_LO];
    next_enhanced_func_en = field_now[`BIT_ENH];
    next_skip_idle_sync = field_now[`BIT_SKIP_SYNC];
    next_mult_power_up = (state != ST_OFF);
    // 40 MHz only for code 01 once locked
    next_mult_clk_40 = (state == ST_RUN) && (cur_mult == `MULT_40MHZ);
    next_pll_locked = (state == ST_RUN);
  end

  // read data holds until the next read of this register
  always @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= next_rdata;
    end
  end

  // field outputs mirror the stored register one cycle later; fast_read_active also needs mux_bus low
  always @(posedge clk) begin
    if (reset) begin
      fast_read_timing_sel <= 1'b0;
      fast_read_active <= 1'b0;
      clock_mult_sel_hi <= 1'b0;
      clock_mult_sel_lo <= 1'b0;
      enhanced_func_en <= 1'b0;
      skip_idle_sync <= 1'b0;
    end else if (ce) begin
      fast_read_timing_sel <= next_fast_read_timing_sel;
      fast_read_active <= next_fast_read_active;
      clock_mult_sel_hi <= next_clock_mult_sel_hi;
      clock_mult_sel_lo <= next_clock_mult_sel_lo;
      enhanced_func_en <= next_enhanced_func_en;
      skip_idle_sync <= next_skip_idle_sync;
    end
  end

  // status outputs follow the wake sequence
  always @(posedge clk) begin
    if (reset) begin
      mult_power_up <= 1'b0;
      mult_clk_40 <= 1'b0;
      pll_locked <= 1'b0;
    end else if (ce) begin
      mult_power_up <= next_mult_power_up;
      mult_clk_40 <= next_mult_clk_40;
      pll_locked <= next_pll_locked;
    end
  end
endmodule

/* tb/setup_props.sv */
// Purpose: port checks for setup register
// Assumes: lock count 16
// Notes: bound to setup_clock_multiplier_config
module setup_props(
  input wire clk, input wire reset, input wire ce, input wire wr, input wire mux_bus,
  input wire [2:0] addr, input wire [7:0] wdata, input wire fast_read_timing_sel,
  input wire fast_read_active, input wire clock_mult_sel_lo, input wire mult_power_up,
  input wire pll_locked, input wire core_halted);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire su = ce && wr && addr == 3'h7;
  wire go = ce && wr && addr == 3'h1 && wdata == 8'h18;
  sequence s_lock; !pll_locked [*8] ##[1:24] pll_locked; endsequence
  property p_fast; su |-> ##2 fast_read_timing_sel == $past(wdata[7], 2); endproperty
  a_fast: assert property (p_fast) else $error("fast bit");
  property p_act; mux_bus [*3] |-> !fast_read_active; endproperty
  a_act: assert property (p_act) else $error("fast on mux");
  property p_lo; su |-> ##2 clock_mult_sel_lo == $past(wdata[4], 2); endproperty
  a_lo: assert property (p_lo) else $error("mult bit");
  property p_pwr; $rose(mult_power_up) |-> $past(su && wdata[5:4] != 2'h0, 2); endproperty
  a_pwr: assert property (p_pwr) else $error("power up");
  property p_halt;
    su && wdata[5:4] == 2'h1 && !mult_power_up && !core_halted |=> core_halted;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt");
  property p_lock; $rose(mult_power_up) |-> s_lock; endproperty
  a_lock: assert property (p_lock) else $error("lock time");
  property p_go; go |=> !core_halted; endproperty
  a_go: assert property (p_go) else $error("no restart");
  property p_hold; core_halted && !go && !$past(go) |=> core_halted; endproperty
  a_hold: assert property (p_hold) else $error("halt lost");
endmodule
bind setup_clock_multiplier_config setup_props setup_props_i(.clk, .reset, .ce, .wr,
  .mux_bus, .addr, .wdata, .fast_read_timing_sel, .fast_read_active, .clock_mult_sel_lo,
  .mult_power_up, .pll_locked, .core_halted);

/* tb/host_bus.sv */
// Purpose: host side of register bus
// Assumes: one-cycle strobes
// Notes: idle data is inverted
module host_bus(
  input wire clk,
  input wire [7:0] rdata,
  output logic [2:0] addr = 3'h0,
  output logic [7:0] wdata = 8'h00,
  output logic wr = 1'b0,
  output logic rd = 1'b0);
  timeunit 1ns;
  timeprecision 1ps;
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  task rd_reg(output logic [7:0] d);
    @(posedge clk);
    addr <= 3'h7;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    d = rdata;
  endtask
endmodule

/* tb/setup_clock_multiplier_config_tb_top.sv */
// Purpose: bench for setup register
// Assumes: lock count 16
// Notes: none
module setup_clock_multiplier_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic mux_bus = 1'b0;
  logic [7:0] d;
  wire [2:0] addr;
  wire [7:0] wdata, rdata;
  wire wr, rd, f7, hi, lo, ef, ns, act, pu, c40, hlt, lk;
  int n_mismatch = 0;
  int n_tests = 0;
  wire [9:0] st = {pu, lk, f7, hi, lo, ef, ns, act, c40, hlt};
  always #2 clk = ~clk;
  host_bus host_bus_i(.clk, .rdata, .addr, .wdata, .wr, .rd);
  setup_clock_multiplier_config #(.LOCK_CYCLES(16)) setup_clock_multiplier_config_i(
    .clk, .reset, .ce, .addr, .wdata, .wr, .rd, .mux_bus, .rdata,
    .fast_read_timing_sel(f7), .fast_read_active(act), .clock_mult_sel_hi(hi),
    .clock_mult_sel_lo(lo), .enhanced_func_en(ef), .skip_idle_sync(ns),
    .mult_power_up(pu), .mult_clk_40(c40), .core_halted(hlt), .pll_locked(lk));
  task end_sim;
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [9:0] e, input logic [9:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task rchk(input logic [7:0] e, input logic [9:0] se);
    host_bus_i.rd_reg(d);
    chk("setup", {2'b00, e}, {2'b00, d});
    chk("state", se, st);
  endtask
  task wait_lock(input logic [9:0] e);
    for (int i = 0; i < 40 && !lk; i++) @(negedge clk);
    chk("lock", e, {7'h00, pu, lk, c40});
    if (!lk) begin
      n_mismatch++;
      end_sim;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rchk(8'h00, 10'h000);
    host_bus_i.wr_reg(3'h7, 8'hdc);
    rchk(8'hdc, 10'h2bd);
    wait_lock(10'h007);
    @(posedge clk);
    mux_bus <= 1'b1;
    rchk(8'hdc, 10'h3bb);
    host_bus_i.wr_reg(3'h1, 8'h18);
    host_bus_i.wr_reg(3'h5, 8'hff);
    rchk(8'hdc, 10'h3ba);
    host_bus_i.wr_reg(3'h7, 8'h10);
    rchk(8'h10, 10'h322);
    host_bus_i.wr_reg(3'h7, 8'h00);
    rchk(8'h00, 10'h300);
    @(posedge clk);
    ce <= 1'b0;
    host_bus_i.wr_reg(3'h7, 8'h84);
    ce <= 1'b1;
    rchk(8'h00, 10'h300);
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rchk(8'h00, 10'h000);
    host_bus_i.wr_reg(3'h7, 8'h20);
    rchk(8'h20, 10'h241);
    wait_lock(10'h006);
    end_sim;
  end
endmodule
